// ---- tio_params.svh ----
// Register map, field positions, reset values and timing counts for tio
`ifndef TIO_PARAMS_SVH
`define TIO_PARAMS_SVH

// Register offsets (8-bit data address space)
`define TIO_ADDR_CONFIG      8'h81
`define TIO_ADDR_IRQ_STATUS  8'h90
`define TIO_ADDR_IRQ_MASK    8'h91
`define TIO_ADDR_TIMER       8'h92

// Configuration register field positions
`define TIO_BIT_PULLUP_OFF   7
`define TIO_BIT_IRQ_EDGE     6
`define TIO_BIT_CLK_SRC      5
`define TIO_BIT_SRC_EDGE     4
`define TIO_BIT_PS_ASSIGN    3
`define TIO_PS_RATE_MSB      2
`define TIO_PS_RATE_LSB      0

// Interrupt status field positions
`define TIO_IRQ_EXT          0
`define TIO_IRQ_TIMER_OVF    1

// Reset values
`define TIO_RST_CONFIG       8'hff
`define TIO_RST_MASK         8'h00

// Instruction cycle: one tick every N core clocks
`define TIO_INSTR_DIV        4

`endif

// ---- tio_pkg.sv ----
// Types shared by the tio configuration block
package tio_pkg;
   typedef logic [7:0] tio_byte_t;
   typedef logic [2:0] tio_rate_t;
endpackage : tio_pkg

// ---- tio_config.sv ----
// Timer, external interrupt and pull-up configuration register block
`timescale 1ns/1ps
`include "tio_params.svh"

module tio_config #(
   parameter int unsigned PORT_W = 8
) (
   // Clock and reset
   input  wire  logic                mclk,
   input  wire  logic                rst_b,
   // Register port
   input  wire  logic [7:0]          reg_addr,
   input  wire  tio_pkg::tio_byte_t  reg_wdata,
   input  wire  logic                reg_wr,
   input  wire  logic                reg_rd,
   output tio_pkg::tio_byte_t        reg_rdata,
   // Pins (asynchronous)
   input  wire  logic                ext_irq_pin,
   input  wire  logic                timer_ext_clk_pin,
   // Port B latch and pull-up enables
   input  wire  logic [PORT_W-1:0]   port_b_a,
   output logic [PORT_W-1:0]         port_b_pullup_en,
   // Control outputs to watchdog and prescaler
   output logic                      prescaler_assign,
   output tio_pkg::tio_rate_t        prescale_rate,
   output logic                      watchdog_tick,
   // Interrupt
   output logic                      irq
);
   import tio_pkg::*;

   tio_byte_t cfg;
   tio_byte_t irq_status;
   tio_byte_t irq_mask;
   tio_byte_t tick_timer;
   logic      port_b_pullup_off;
   logic      ext_irq_edge_sel;
   logic      timer_clk_src_sel;
   logic      timer_src_edge_sel;
   logic      wr_cfg;
   logic      wr_stat;
   logic      wr_mask;
   logic      wr_tmr;

   // Field view of the configuration register
   assign port_b_pullup_off  = cfg[`TIO_BIT_PULLUP_OFF];
   assign ext_irq_edge_sel   = cfg[`TIO_BIT_IRQ_EDGE];
   assign timer_clk_src_sel  = cfg[`TIO_BIT_CLK_SRC];
   assign timer_src_edge_sel = cfg[`TIO_BIT_SRC_EDGE];
   assign prescaler_assign   = cfg[`TIO_BIT_PS_ASSIGN];
   assign prescale_rate      = cfg[`TIO_PS_RATE_MSB:`TIO_PS_RATE_LSB];

   // Address decode
   assign wr_cfg  = reg_wr && (reg_addr == `TIO_ADDR_CONFIG);
   assign wr_stat = reg_wr && (reg_addr == `TIO_ADDR_IRQ_STATUS);
   assign wr_mask = reg_wr && (reg_addr == `TIO_ADDR_IRQ_MASK);
   assign wr_tmr  = reg_wr && (reg_addr == `TIO_ADDR_TIMER);

   // Configuration register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cfg <= `TIO_RST_CONFIG;
      end else if (wr_cfg) begin
         cfg <= reg_wdata;
      end
   end

   // Interrupt mask register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         irq_mask <= `TIO_RST_MASK;
      end else if (wr_mask) begin
         irq_mask <= reg_wdata;
      end
   end

   // Pull-ups: a global kill overrides every per-pin latch value
   always_comb begin
      for (int i = 0; i < PORT_W; i++) begin
         port_b_pullup_en[i] = !port_b_pullup_off && port_b_a[i];
      end
   end

   // Three-flop chains: two-flop synchroniser plus edge-history stage; first stage is read only by the second
   logic irq_s1;
   logic irq_s2;
   logic irq_s3;
   logic tck_s1;
   logic tck_s2;
   logic tck_s3;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         irq_s1 <= 1'b0;
         irq_s2 <= 1'b0;
         irq_s3 <= 1'b0;
         tck_s1 <= 1'b0;
         tck_s2 <= 1'b0;
         tck_s3 <= 1'b0;
      end else begin
         irq_s1 <= ext_irq_pin;
         irq_s2 <= irq_s1;
         irq_s3 <= irq_s2;
         tck_s1 <= timer_ext_clk_pin;
         tck_s2 <= tck_s1;
         tck_s3 <= tck_s2;
      end
   end

   // Edge detection on synchronised pins
   logic ext_irq_evt;
   logic ext_clk_evt;
   assign ext_irq_evt = ext_irq_edge_sel ? (irq_s2 && !irq_s3)
                                         : (!irq_s2 && irq_s3);
   assign ext_clk_evt = timer_src_edge_sel ? (!tck_s2 && tck_s3)
                                           : (tck_s2 && !tck_s3);

   // Instruction cycle divider, one-cycle enable pulse
   logic [1:0] div_cnt;
   logic       instr_cycle_clk;
   assign instr_cycle_clk = (div_cnt == 2'(`TIO_INSTR_DIV - 1));
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt <= 2'h0;
      end else begin
         div_cnt <= div_cnt + 2'h1;
      end
   end

   // Source selection for the timer count
   logic src_tick;
   assign src_tick = timer_clk_src_sel ? ext_clk_evt : instr_cycle_clk;

   // Shared prescaler: counts source ticks or watchdog cycles
   logic [7:0] ps_cnt;
   logic       ps_out;
   logic       ps_in;
   logic [7:0] ps_top;
   assign ps_in  = prescaler_assign ? instr_cycle_clk : src_tick;
   assign ps_top = 8'((9'h002 << prescale_rate) - 9'h001);
   assign ps_out = ps_in && (ps_cnt == ps_top);
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ps_cnt <= 8'h00;
      end else if (wr_tmr || wr_cfg) begin
         ps_cnt <= 8'h00; // Reassigning prescaler starts it afresh
      end else if (ps_in) begin
         ps_cnt <= ps_out ? 8'h00 : ps_cnt + 8'h01;
      end
   end

   // Timer tick: bypass prescaler when it belongs to the watchdog
   logic timer_inc;
   assign timer_inc     = prescaler_assign ? src_tick : ps_out;
   assign watchdog_tick = prescaler_assign ? ps_out : instr_cycle_clk;

   // Timer counter
   logic timer_ovf;
   assign timer_ovf = timer_inc && (tick_timer == 8'hff);
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tick_timer <= 8'h00;
      end else if (wr_tmr) begin
         tick_timer <= reg_wdata;
      end else if (timer_inc) begin
         tick_timer <= tick_timer + 8'h01;
      end
   end

   // Sticky status; set wins over write-one-to-clear
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         irq_status <= 8'h00;
      end else begin
         for (int b = 0; b < 8; b++) begin
            if ((b == `TIO_IRQ_EXT && ext_irq_evt) ||
                (b == `TIO_IRQ_TIMER_OVF && timer_ovf)) begin
               irq_status[b] <= 1'b1;
            end else if (wr_stat && reg_wdata[b]) begin
               irq_status[b] <= 1'b0;
            end
         end
      end
   end

   // Level interrupt
   assign irq = |(irq_status & irq_mask);

   // Read data, one cycle after the strobe; unmapped reads return zero
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `TIO_ADDR_CONFIG:     reg_rdata <= cfg;
            `TIO_ADDR_IRQ_STATUS: reg_rdata <= irq_status;
            `TIO_ADDR_IRQ_MASK:   reg_rdata <= irq_mask;
            `TIO_ADDR_TIMER:      reg_rdata <= tick_timer;
            default:              reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule : tio_config

// ---- tio_config_assertions.sv ----
// Port-level checks for the tio configuration block
`timescale 1ns/1ps
module tio_config_assertions import tio_pkg::*; #(
   parameter int unsigned PORT_W = 8
) (
   input wire logic              mclk,
   input wire logic              rst_b,
   input wire logic [7:0]        reg_addr,
   input wire tio_byte_t         reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire tio_byte_t         reg_rdata,
   input wire logic              ext_irq_pin,
   input wire logic [PORT_W-1:0] port_b_a,
   input wire logic [PORT_W-1:0] port_b_pullup_en,
   input wire logic              prescaler_assign,
   input wire tio_rate_t         prescale_rate,
   input wire logic              watchdog_tick,
   input wire logic              irq
);
   logic [7:0] cfg;
   logic [7:0] msk;
   // Shadow of config and mask, seen only through writes
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cfg <= 8'hff;
         msk <= 8'h00;
      end else if (reg_wr) begin
         if (reg_addr == 8'h81) cfg <= reg_wdata;
         if (reg_addr == 8'h91) msk <= reg_wdata;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   chk_read_back: assert property (reg_rd && reg_addr == 8'h81
      |=> reg_rdata == $past(cfg)) else $error("config readback wrong");
   chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   chk_write_lands: assert property (reg_wr && reg_addr == 8'h81
      |=> {prescaler_assign, prescale_rate} == $past(reg_wdata[3:0]))
      else $error("config write not applied");
   chk_pullup_map: assert property (port_b_pullup_en ==
      (cfg[7] ? '0 : port_b_a)) else $error("pull-up enables wrong");
   chk_assign_lvl: assert property (prescaler_assign == cfg[3])
      else $error("prescaler assignment wrong");
   chk_rate_lvl: assert property (prescale_rate == cfg[2:0])
      else $error("prescale rate wrong");
   chk_irq_edge: assert property (msk[0] && (cfg[6] ?
      $rose(ext_irq_pin) : $fell(ext_irq_pin)) |-> ##[1:6] irq)
      else $error("selected pin edge gave no interrupt");
   chk_irq_masked: assert property (msk == 8'h00 |-> !irq)
      else $error("interrupt while fully masked");
   chk_tick_gap: assert property (watchdog_tick |=> !watchdog_tick [*3])
      else $error("watchdog ticks too close");
endmodule : tio_config_assertions

bind tio_config tio_config_assertions #(.PORT_W(PORT_W)) chk (.*);

// ---- tio_config_bench.sv ----
// Self-checking bench for the tio configuration block
`timescale 1ns/1ps
module tio_config_bench;
   import tio_pkg::*;
   logic       mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
   logic       ext_irq_pin = 0, timer_ext_clk_pin = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, port_b_a = 0, s = 8'h49;
   logic [7:0] port_b_pullup_en;
   tio_byte_t  reg_rdata;
   tio_rate_t  prescale_rate;
   logic       prescaler_assign, watchdog_tick, irq;
   int         err_total = 0, cmp_count = 0;
   tio_config uut (.*);
   always #2 mclk = ~mclk;
   // Eight-bit LFSR, fixed start value for repeatable runs
   function logic [7:0] nx(logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : nx
   task cmp(string n, logic [7:0] e, logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : cmp
   task wr(logic [7:0] a, logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1;
      @(posedge mclk);
      reg_wr <= 0;
   endtask : wr
   // Read data is only valid in the slot after the strobe
   task rd(logic [7:0] a, logic [7:0] e, string n);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge mclk);
      reg_rd <= 0;
      @(negedge mclk);
      cmp(n, e, reg_rdata);
   endtask : rd
   // Slow toggles so every level survives the synchroniser
   task tog(int n);
      repeat (n) begin
         repeat (4) @(posedge mclk);
         timer_ext_clk_pin <= ~timer_ext_clk_pin;
      end
      repeat (6) @(posedge mclk);
   endtask : tog
   task edge_chk(logic v, logic e, string n);
      @(posedge mclk);
      ext_irq_pin <= v;
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      cmp(n, {7'h00, e}, {7'h00, irq});
      wr(8'h90, 8'h01);
   endtask : edge_chk
   task stop_test;
      $display("Errors %0d, checks %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test
   // Main sequence
   initial begin
      repeat (4) @(posedge mclk);
      rst_b <= 1;
      rd(8'h81, 8'hff, "cfg reset");
      rd(8'h55, 8'h00, "unmapped");
      for (int i = 0; i < 24; i++) begin
         s = nx(s);
         wr(8'h81, s);
         port_b_a <= nx(s);
         rd(8'h81, s, "cfg");
         cmp("pullup", s[7] ? 8'h00 : nx(s), port_b_pullup_en);
         cmp("assign", s[3:0], {prescaler_assign, prescale_rate});
      end
      wr(8'h91, 8'h01);
      wr(8'h81, 8'h40);
      edge_chk(1, 1, "rise");
      edge_chk(0, 0, "fall ignored");
      wr(8'h81, 8'h00);
      edge_chk(1, 0, "rise ignored");
      edge_chk(0, 1, "fall");
      wr(8'h81, 8'h28);
      wr(8'h92, 8'h00);
      tog(9);
      rd(8'h92, 8'h05, "rise count");
      wr(8'h81, 8'h38);
      wr(8'h92, 8'h00);
      tog(7);
      rd(8'h92, 8'h04, "fall count");
      // Prescaler on the timer at rate 0 halves the rising-edge count
      wr(8'h81, 8'h20);
      wr(8'h92, 8'h00);
      tog(8);
      rd(8'h92, 8'h02, "prescaled count");
      stop_test;
   end
   // Run needs about 290 cycles; over fifty times that is a hang
   initial begin
      #60000;
      err_total++;
      stop_test;
   end
endmodule : tio_config_bench
